// ===== sr1k_host.sv
// Purpose: Host controller driving a 1K x 4 asynchronous static memory
// Assumes: Pin inputs synchronous to clk_sys; fastest speed grade
// Notes:   One request at a time; pins are registered one cycle behind state
`timescale 1ns/1ps
`default_nettype none
module sr1k_host (
  input  wire logic                          clk_sys,           // 40 MHz clock
  input  wire logic                          rst,               // Sync reset, active high
  input  wire logic                          req_valid,         // Request present
  input  wire logic                          req_write,         // 1 write, 0 read
  input  wire logic [sr1k_pkg::INDEX_W-1:0]  req_index,         // Word to access
  input  wire logic [sr1k_pkg::NIB_W-1:0]    req_wdata,         // Write nibble
  output logic                               req_ready,         // Request taken when high
  output logic                               rsp_valid,         // Read data pulse
  output logic [sr1k_pkg::NIB_W-1:0]         rsp_rdata,         // Read nibble
  output logic                               wr_done,           // Write finished pulse
  output logic [sr1k_pkg::INDEX_W-1:0]       word_index,        // Memory index pins
  output logic                               sel_n,             // Chip enable, active low
  output logic                               store_n,           // Store strobe, active low
  input  wire logic [sr1k_pkg::NIB_W-1:0]    nibble_lines_i,    // Nibble lines in
  output logic [sr1k_pkg::NIB_W-1:0]         nibble_lines_o,    // Nibble lines out
  output logic                               nibble_lines_oe_n  // Low while host drives
);
  sr1k_pins_if pins ();

  sr1k_pkg::sr1k_state_t               state_r, state_nxt;
  logic [sr1k_pkg::CNT_W-1:0]          cnt_r, cnt_nxt;
  logic [sr1k_pkg::INDEX_W-1:0]        idx_r, idx_nxt;
  logic [sr1k_pkg::NIB_W-1:0]          wdat_r, wdat_nxt;
  logic [sr1k_pkg::NIB_W-1:0]          rdat_r, rdat_nxt;
  logic                                sel_r, sel_nxt, st_r, st_nxt, drv_r, drv_nxt;
  logic                                rv_r, rv_nxt, wd_r, wd_nxt;

  // Cycle count as counter width, loaded minus one
  function automatic logic [sr1k_pkg::CNT_W-1:0] cyc(input int n);
    cyc = sr1k_pkg::CNT_W'(n - 1);
  endfunction

  // ==========================================================================
  // Sequencer next state
  // The index only changes in idle, where the strobe is high.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    idx_nxt   = idx_r;
    wdat_nxt  = wdat_r;
    rdat_nxt  = rdat_r;
    sel_nxt   = sel_r;
    st_nxt    = st_r;
    drv_nxt   = drv_r;
    rv_nxt    = 1'b0;
    wd_nxt    = 1'b0;
    case (state_r)
      sr1k_pkg::SR1K_IDLE: begin
        // Static storage: idle needs no refresh or keep-alive cycles
        st_nxt  = 1'b1;
        drv_nxt = 1'b0;
        if (req_valid) begin
          idx_nxt  = req_index;
          wdat_nxt = req_wdata;
          sel_nxt  = 1'b0;
          if (req_write) begin
            // Drive data first; strobe follows, so write data covers the overlap
            drv_nxt   = 1'b1;
            state_nxt = sr1k_pkg::SR1K_WR_SETUP;
          end else begin
            cnt_nxt   = cyc(sr1k_pkg::ACCESS_CYC);
            state_nxt = sr1k_pkg::SR1K_RD_WAIT;
          end
        end else begin
          sel_nxt = 1'b1;
        end
      end
      sr1k_pkg::SR1K_RD_WAIT: begin
        // Wait full access count; read sampled at end, one cycle short of it at the lagging pins
        if (cnt_r == sr1k_pkg::CNT_ZERO) begin
          rdat_nxt  = nibble_lines_i;
          rv_nxt    = 1'b1;
          sel_nxt   = 1'b1;
          cnt_nxt   = cyc(sr1k_pkg::RELEASE_CYC);
          state_nxt = sr1k_pkg::SR1K_TURN;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      sr1k_pkg::SR1K_WR_SETUP: begin
        // Data already on the lines; now lower strobe for the write pulse
        st_nxt    = 1'b0;
        cnt_nxt   = cyc(sr1k_pkg::STROBE_CYC > sr1k_pkg::OVERLAP_CYC ?
                        sr1k_pkg::STROBE_CYC : sr1k_pkg::OVERLAP_CYC);
        state_nxt = sr1k_pkg::SR1K_WR_STROBE;
      end
      sr1k_pkg::SR1K_WR_STROBE: begin
        if (cnt_r == sr1k_pkg::CNT_ZERO) begin
          st_nxt    = 1'b1;
          cnt_nxt   = cyc(sr1k_pkg::WRITE_CYC - sr1k_pkg::STROBE_CYC - 1);
          state_nxt = sr1k_pkg::SR1K_WR_RECOVER;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      sr1k_pkg::SR1K_WR_RECOVER: begin
        // Data released one clock after the strobe rises
        drv_nxt = 1'b0;
        sel_nxt = 1'b1;
        if (cnt_r == sr1k_pkg::CNT_ZERO) begin
          wd_nxt    = 1'b1;
          state_nxt = sr1k_pkg::SR1K_IDLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      sr1k_pkg::SR1K_TURN: begin
        // Let the memory release its drivers before the next write can drive
        if (cnt_r == sr1k_pkg::CNT_ZERO) begin
          state_nxt = sr1k_pkg::SR1K_IDLE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      default: begin
        state_nxt = sr1k_pkg::SR1K_IDLE;
        sel_nxt   = 1'b1;
        st_nxt    = 1'b1;
        drv_nxt   = 1'b0;
      end
    endcase
  end

  // Register sequencer state
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= sr1k_pkg::SR1K_IDLE;
      cnt_r   <= sr1k_pkg::CNT_ZERO;
      idx_r   <= '0;
      wdat_r  <= '0;
      rdat_r  <= '0;
      sel_r   <= 1'b1;
      st_r    <= 1'b1;
      drv_r   <= 1'b0;
      rv_r    <= 1'b0;
      wd_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      idx_r   <= idx_nxt;
      wdat_r  <= wdat_nxt;
      rdat_r  <= rdat_nxt;
      sel_r   <= sel_nxt;
      st_r    <= st_nxt;
      drv_r   <= drv_nxt;
      rv_r    <= rv_nxt;
      wd_r    <= wd_nxt;
    end
  end

  // ==========================================================================
  // Outputs and pin stage
  assign req_ready       = (state_r == sr1k_pkg::SR1K_IDLE);
  assign rsp_valid       = rv_r;
  assign rsp_rdata       = rdat_r;
  assign wr_done         = wd_r;
  assign pins.word_index = idx_r;
  assign pins.sel_n      = sel_r;
  assign pins.store_n    = st_r;
  assign pins.wdata      = wdat_r;
  assign pins.drive      = drv_r;

  sr1k_pin_drv u_pin_drv (
    .clk_sys           (clk_sys),
    .rst               (rst),
    .pins              (pins),
    .word_index        (word_index),
    .sel_n             (sel_n),
    .store_n           (store_n),
    .nibble_lines_o    (nibble_lines_o),
    .nibble_lines_oe_n (nibble_lines_oe_n)
  );
endmodule // sr1k_host
`default_nettype wire

// ===== sr1k_host_props.sv
// Purpose: Pin timing and answer checks for the static memory host controller
// Assumes: Sees only the top module ports, attached by bind
// Notes:   Cycle figures follow the request walk of the controller
`timescale 1ns/1ps
`default_nettype none
module sr1k_host_props (
  input wire logic                         clk_sys,           // Clock
  input wire logic                         rst,               // Sync reset
  input wire logic                         req_valid,         // Request
  input wire logic                         req_write,         // Write flag
  input wire logic [sr1k_pkg::INDEX_W-1:0] req_index,         // Index asked
  input wire logic [sr1k_pkg::NIB_W-1:0]   req_wdata,         // Nibble asked
  input wire logic                         req_ready,         // Idle
  input wire logic                         rsp_valid,         // Read pulse
  input wire logic [sr1k_pkg::NIB_W-1:0]   rsp_rdata,         // Read nibble
  input wire logic                         wr_done,           // Write pulse
  input wire logic [sr1k_pkg::INDEX_W-1:0] word_index,        // Index pins
  input wire logic                         sel_n,             // Enable pin
  input wire logic                         store_n,           // Strobe pin
  input wire logic [sr1k_pkg::NIB_W-1:0]   nibble_lines_i,    // Lines in
  input wire logic [sr1k_pkg::NIB_W-1:0]   nibble_lines_o,    // Lines out
  input wire logic                         nibble_lines_oe_n  // Host drive
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Accepted requests
  sequence rd_take; req_valid && req_ready && !req_write; endsequence
  sequence wr_take; req_valid && req_ready && req_write; endsequence
  a_read_answer:
    assert property (rd_take |=> (!rsp_valid)[*8] ##1 rsp_valid) else $error("read answer off");
  // Write: strobe sequence ends eight edges after the take, pulse seen at the ninth
  a_write_answer:
    assert property (wr_take |=> (!wr_done)[*8] ##1 wr_done) else $error("write answer off");
  // Read holds the controller busy through the turnaround
  a_busy_span:
    assert property (rd_take |=> (!req_ready)[*8] ##4 req_ready)
      else $error("busy span off");
  // Write cycle is one full write period of eight clocks
  a_write_busy:
    assert property (wr_take |=> (!req_ready)[*8] ##1 req_ready)
      else $error("write busy span off");
  // Reads keep the host off the shared lines for the whole select window
  a_read_window:
    assert property (rd_take |-> ##2 (!sel_n && store_n && nibble_lines_oe_n)[*8] ##1 sel_n)
      else $error("read window off");
  a_write_setup:
    assert property (wr_take |-> ##2 !sel_n && !nibble_lines_oe_n
      && word_index == $past(req_index, 2) && nibble_lines_o == $past(req_wdata, 2))
      else $error("write setup off");
  // Strobe pulse must cover both the width and the data overlap
  a_strobe_width:
    assert property ($fell(store_n) |-> (!store_n)[*5] ##1 store_n) else $error("strobe width");
  a_data_overlap:
    assert property (!store_n |-> !sel_n && !nibble_lines_oe_n && $stable(nibble_lines_o))
      else $error("data not held under strobe");
  a_index_strobe_high:
    assert property (!$stable(word_index) |-> store_n && $past(store_n))
      else $error("index moved under strobe");
  a_no_joint_fall:
    assert property ($fell(store_n) |-> $past(!sel_n)) else $error("enable and strobe fell together");
  a_write_release:
    assert property ($rose(store_n) |=> sel_n && nibble_lines_oe_n) else $error("write release off");
  a_read_polarity:
    assert property (rsp_valid |-> rsp_rdata == $past(nibble_lines_i)) else $error("read data altered");
endmodule // sr1k_host_props
bind sr1k_host sr1k_host_props sr1k_host_props_inst (
  .clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_write(req_write),
  .req_index(req_index), .req_wdata(req_wdata), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .wr_done(wr_done),
  .word_index(word_index), .sel_n(sel_n), .store_n(store_n),
  .nibble_lines_i(nibble_lines_i), .nibble_lines_o(nibble_lines_o),
  .nibble_lines_oe_n(nibble_lines_oe_n));
`default_nettype wire

// ===== sr1k_mem_model.sv
// Purpose: Behavioural 1K x 4 static memory with shared nibble lines
// Assumes: Pins change on clock edges; settle time counted in clocks
// Notes:   Released lines show a toggling pattern, never the last value
`timescale 1ns/1ps
`default_nettype none
module sr1k_mem_model (
  input  wire logic                         clk_sys,    // Clock for settle count
  input  wire logic                         slow,       // Long access when high
  input  wire logic [sr1k_pkg::INDEX_W-1:0] word_index, // Index pins
  input  wire logic                         sel_n,      // Enable, active low
  input  wire logic                         store_n,    // Strobe, active low
  input  wire logic [sr1k_pkg::NIB_W-1:0]   host_o,     // Host data
  input  wire logic                         host_oe_n,  // Host drives when low
  output logic      [sr1k_pkg::NIB_W-1:0]   lines       // Resolved lines
);
  logic [sr1k_pkg::NIB_W-1:0]   mem [sr1k_pkg::WORDS];
  logic [sr1k_pkg::INDEX_W-1:0] idx_q;
  logic [3:0]                   settle = 4'h0;
  logic [3:0]                   flt = 4'hA;
  logic                         rd;
  logic                         rd_q;
  // Read only while selected with strobe high; deselect ignores all else
  assign rd = !sel_n && store_n;
  // Drivers wait at least one cycle, longer when slow, restarting on a new index
  assign rd_q = rd && settle >= (slow ? 4'h5 : 4'h1);
  // Settle count, floating pattern and stores
  always @(posedge clk_sys) begin
    idx_q <= word_index;
    flt <= ~flt;
    settle <= (!rd || word_index != idx_q) ? 4'h0 : settle + 4'h1;
    if (!sel_n && !store_n && !host_oe_n) mem[word_index] <= lines;
  end
  // Wire resolution, no inversion on read
  assign lines = !host_oe_n ? host_o : rd_q ? mem[word_index] : flt;
endmodule // sr1k_mem_model
`default_nettype wire

// ===== sr1k_pin_drv.sv
// Purpose: Registers the memory pins so they change only on clock edges
// Assumes: Sequencer holds the store strobe high across index changes
// Notes:   Output enable low means the host drives the nibble lines
`timescale 1ns/1ps
`default_nettype none
module sr1k_pin_drv (
  input  wire logic                          clk_sys,        // System clock
  input  wire logic                          rst,            // Sync reset, active high
  sr1k_pins_if.drv                           pins,           // From sequencer
  output logic [sr1k_pkg::INDEX_W-1:0]       word_index,     // Word index pins
  output logic                               sel_n,          // Chip enable, active low
  output logic                               store_n,        // Store strobe, active low
  output logic [sr1k_pkg::NIB_W-1:0]         nibble_lines_o, // Nibble data out
  output logic                               nibble_lines_oe_n // Low while host drives
);
  logic [sr1k_pkg::INDEX_W-1:0] idx_r, idx_nxt;
  logic                         sel_r, sel_nxt, st_r, st_nxt, oe_r, oe_nxt;
  logic [sr1k_pkg::NIB_W-1:0]   dat_r, dat_nxt;

  // ==========================================================================
  // Next values: deselected idle state under reset
  always_comb begin
    idx_nxt = pins.word_index;
    sel_nxt = pins.sel_n;
    st_nxt  = pins.store_n;
    dat_nxt = pins.wdata;
    oe_nxt  = ~pins.drive;
  end

  // Registered pins avoid glitches on the strobes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      idx_r <= '0;
      sel_r <= 1'b1;
      st_r  <= 1'b1;
      dat_r <= '0;
      oe_r  <= 1'b1;
    end else begin
      idx_r <= idx_nxt;
      sel_r <= sel_nxt;
      st_r  <= st_nxt;
      dat_r <= dat_nxt;
      oe_r  <= oe_nxt;
    end
  end

  assign word_index        = idx_r;
  assign sel_n             = sel_r;
  assign store_n           = st_r;
  assign nibble_lines_o    = dat_r;
  assign nibble_lines_oe_n = oe_r;
endmodule // sr1k_pin_drv
`default_nettype wire

// ===== sr1k_pins_if.sv
// Purpose: Pin-side bundle between sequencer and pin driver
// Assumes: Single clock domain
// Notes:   Drive flag for the nibble lines is active high; the pin driver inverts it
`timescale 1ns/1ps
`default_nettype none
interface sr1k_pins_if;
  logic [sr1k_pkg::INDEX_W-1:0] word_index;
  logic                         sel_n;
  logic                         store_n;
  logic [sr1k_pkg::NIB_W-1:0]   wdata;
  logic                         drive;
  modport seq (output word_index, sel_n, store_n, wdata, drive);
  modport drv (input word_index, sel_n, store_n, wdata, drive);
endinterface
`default_nettype wire

// ===== sr1k_pkg.sv
// Purpose: Shared constants and types for the 1K x 4 static memory host controller
// Assumes: 40 MHz system clock, fastest speed grade timing
// Notes:   Times in ns, cycle counts derived from them
package sr1k_pkg;
  // ==========================================================================
  // Geometry
  localparam int INDEX_W = 10;
  localparam int NIB_W   = 4;
  localparam int WORDS   = 1024;
  // ==========================================================================
  // Timing
  localparam int CLK_NS               = 25;
  localparam int READ_PERIOD_NS       = 200;  // Cycle equals access time
  localparam int ACCESS_DELAY_NS      = 200;
  localparam int SEL_TO_VALID_NS      = 70;
  localparam int SEL_TO_ACTIVE_NS     = 20;
  localparam int RELEASE_NS           = 60;   // Drivers off after deselect or strobe
  localparam int HOLD_AFTER_INDEX_NS  = 50;
  localparam int WRITE_PERIOD_NS      = 200;
  localparam int STROBE_LOW_WIDTH_NS  = 120;
  localparam int DATA_OVERLAP_NS      = 120;
  localparam int DATA_KEEP_NS         = 0;
  // Least times round up
  localparam int READ_CYC   = (READ_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_CYC = (ACCESS_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_LOW_WIDTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int OVERLAP_CYC = (DATA_OVERLAP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_CYC  = (WRITE_PERIOD_NS + CLK_NS - 1) / CLK_NS;
  localparam int RELEASE_CYC = (RELEASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  // ==========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    SR1K_IDLE,
    SR1K_RD_WAIT,
    SR1K_WR_SETUP,
    SR1K_WR_STROBE,
    SR1K_WR_RECOVER,
    SR1K_TURN
  } sr1k_state_t;
endpackage

// ===== testbench.sv
// Purpose: Self-checking bench for the static memory host controller
// Assumes: Partner model on the pins; stimulus on falling edges
// Notes:   Expected results queue up in request order
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [9:0]  req_index = 10'h000;
  logic [3:0]  req_wdata = 4'h0;
  logic        slow = 1'b0;
  logic        req_ready, rsp_valid, wr_done, sel_n, store_n, oe_n;
  logic [3:0]  rsp_rdata, host_o, nib;
  logic [9:0]  word_index;
  logic [3:0]  exp_mem [1024];
  logic [9:0]  idx [12];
  logic [4:0]  q [$];
  logic [4:0]  e;
  int          miscompares = 0;
  int          n_tests = 0;
  sr1k_host sr1k_host_inst (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
    .req_write(req_write), .req_index(req_index), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .wr_done(wr_done),
    .word_index(word_index), .sel_n(sel_n), .store_n(store_n), .nibble_lines_i(nib),
    .nibble_lines_o(host_o), .nibble_lines_oe_n(oe_n));
  sr1k_mem_model sr1k_mem_model_inst (.clk_sys(clk_sys), .slow(slow), .word_index(word_index),
    .sel_n(sel_n), .store_n(store_n), .host_o(host_o), .host_oe_n(oe_n), .lines(nib));
  // ==========================================================================
  // Clock and helpers
  always #12.5 clk_sys = ~clk_sys;
  task automatic check(input string what, input logic [4:0] seen, input logic [4:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Holds the request until taken, then notes the expected result
  task automatic do_req(input logic w, input logic [9:0] i, input logic [3:0] d);
    int n;
    // Let an edge pass so the previous release is seen before the next request
    @(negedge clk_sys);
    req_valid = 1'b1;
    req_write = w;
    req_index = i;
    req_wdata = d;
    for (n = 0; n < 50 && req_ready !== 1'b1; n++) @(negedge clk_sys);
    if (n == 50) begin
      miscompares++;
      final_report();
    end
    q.push_back(w ? 5'h00 : {1'b1, exp_mem[i]});
    if (w) exp_mem[i] = d;
    @(negedge clk_sys);
    req_valid = 1'b0;
  endtask
  // Bounded wait until every noted result has shown up
  task automatic drain;
    int n;
    for (n = 0; n < 100 && (q.size() != 0 || req_ready !== 1'b1); n++) @(negedge clk_sys);
    if (n == 100) begin
      miscompares++;
      final_report();
    end
  endtask
  // ==========================================================================
  // Result monitor: a write shows as zero, a read as flag and nibble
  // Sampled mid-cycle so registered pulses are settled
  always @(negedge clk_sys) begin
    if (!rst && (rsp_valid === 1'b1 || wr_done === 1'b1)) begin
      e = (q.size() != 0) ? q.pop_front() : 5'bx;
      check("result", {rsp_valid, rsp_valid ? rsp_rdata : 4'h0}, e);
    end
  end
  // Hang guard well above the longest sequence
  initial begin
    repeat (20000) @(posedge clk_sys);
    miscompares++;
    final_report();
  end
  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(32'hA8923471));
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    // Edge words then random ones, written back to back, then read back
    for (int i = 0; i < 12; i++) begin
      idx[i] = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($urandom);
      do_req(1'b1, idx[i], 4'($urandom));
    end
    for (int i = 0; i < 12; i++) do_req(1'b0, idx[i], 4'h0);
    // Overwrite a whole word and read it straight after each write
    for (int i = 0; i < 2; i++) begin
      do_req(1'b1, 10'h155, i ? 4'h5 : 4'hA);
      do_req(1'b0, 10'h155, 4'h0);
    end
    // Slow partner answers late but still inside the sample point
    slow = 1'b1;
    for (int i = 0; i < 4; i++) do_req(1'b0, idx[i], 4'h0);
    drain();
    // Controller reset mid-run leaves pins idle and the memory intact
    rst = 1'b1;
    repeat (5) @(negedge clk_sys);
    check("idle pins", {1'b0, sel_n, store_n, oe_n, req_ready}, 5'h0F);
    rst = 1'b0;
    do_req(1'b0, 10'h000, 4'h0);
    do_req(1'b0, 10'h3FF, 4'h0);
    drain();
    final_report();
  end
endmodule // testbench
`default_nettype wire
